//--- asp_serial_port.sv
// Purpose: asynchronous serial port with AHB-Lite register access
// Assumes: rxd synchronous to clk; single word transfers only
// Notes: reads take one wait state, writes none
`include "asp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// serial line
	input wire logic rxd,
	output logic txd,
	output logic txd_oe,
	// interrupt request
	output logic irq
);
	// ****************************************
	// bus slave
	// ****************************************
	asp_pkg::asp_aphase_t ap;
	logic rd_pend;
	logic wr_pend;
	logic [7:0] rd_val;
	wire take = hsel & htrans[1] & hready;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ap <= '0;
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (take) begin
				ap <= '{addr: haddr[7:0], write: hwrite};
				wr_pend <= hwrite;
				rd_pend <= ~hwrite;
				// a read waits one cycle because hrdata is registered from rd_val in the data phase
				hreadyout <= hwrite;
			end else begin
				wr_pend <= 1'b0;
				rd_pend <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end
	wire data_rd = rd_pend & (ap.addr == `ASP_OFF_DATA);
	wire stat_rd = rd_pend & (ap.addr == `ASP_OFF_STAT);
	wire data_wr = wr_pend & (ap.addr == `ASP_OFF_DATA);
	wire ctla_wr = wr_pend & (ap.addr == `ASP_OFF_CTLA);
	wire ctlb_wr = wr_pend & (ap.addr == `ASP_OFF_CTLB);
	wire baud_wr = wr_pend & (ap.addr == `ASP_OFF_BAUD);
	// ****************************************
	// control registers
	// ****************************************
	logic tx_ninth_bit;
	logic char_len_9;
	logic wake_addr_mark;
	logic tx_empty_irq_en;
	logic tx_done_irq_en;
	logic rx_full_irq_en;
	logic line_quiet_irq_en;
	logic tx_enable;
	logic rx_enable;
	logic rx_sleep;
	logic send_break_ctl;
	logic [1:0] prescale_sel;
	logic [2:0] rate_div_sel = 3'h0;
	logic wake_evt;
	wire te_rise = ctlb_wr & hwdata[`ASP_B_TE] & ~tx_enable;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_ninth_bit <= 1'b0;
			char_len_9 <= 1'b0;
			wake_addr_mark <= 1'b0;
		end else if (ctla_wr) begin
			tx_ninth_bit <= hwdata[`ASP_A_T8];
			char_len_9 <= hwdata[`ASP_A_M];
			wake_addr_mark <= hwdata[`ASP_A_WAKE];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_empty_irq_en <= 1'b0;
			tx_done_irq_en <= 1'b0;
			rx_full_irq_en <= 1'b0;
			line_quiet_irq_en <= 1'b0;
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			send_break_ctl <= 1'b0;
		end else if (ctlb_wr) begin
			tx_empty_irq_en <= hwdata[`ASP_B_TIE];
			tx_done_irq_en <= hwdata[`ASP_B_TX_DONE_IRQ_EN];
			rx_full_irq_en <= hwdata[`ASP_B_RIE];
			line_quiet_irq_en <= hwdata[`ASP_B_LINE_QUIET_IRQ_EN];
			tx_enable <= hwdata[`ASP_B_TE];
			rx_enable <= hwdata[`ASP_B_RE];
			send_break_ctl <= hwdata[`ASP_B_SBK];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_sleep <= 1'b0;
		end else if (ctlb_wr) begin
			rx_sleep <= hwdata[`ASP_B_RWU];
		end else if (wake_evt) begin
			rx_sleep <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prescale_sel <= 2'h0;
		end else if (baud_wr) begin
			prescale_sel <= hwdata[`ASP_BD_PRE_HI:`ASP_BD_PRE_LO];
		end
	end
	// rate field keeps its value across reset
	always_ff @(posedge clk) begin
		if (baud_wr) begin
			rate_div_sel <= hwdata[`ASP_BD_RATE_HI:`ASP_BD_RATE_LO];
		end
	end
	// ****************************************
	// bit-rate chain
	// ****************************************
	logic [3:0] pre_cnt;
	logic [3:0] pre_term;
	logic [6:0] rate_cnt;
	logic [3:0] bit_div;
	always_comb begin
		unique case (prescale_sel)
			2'h0: pre_term = `ASP_PRE_T0;
			2'h1: pre_term = `ASP_PRE_T1;
			2'h2: pre_term = `ASP_PRE_T2;
			2'h3: pre_term = `ASP_PRE_T3;
		endcase
	end
	// >= lets a shrinking prescale take effect without wrapping
	wire pre_tick = pre_cnt >= pre_term;
	wire [6:0] rate_term = 7'((8'h01 << rate_div_sel) - 8'h01);
	wire sample_tick_clk = pre_tick & (rate_cnt >= rate_term);
	wire bit_tick = sample_tick_clk & (bit_div == `ASP_RT_LAST);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_cnt <= 4'h0;
		end else begin
			pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rate_cnt <= 7'h0;
		end else if (pre_tick) begin
			rate_cnt <= sample_tick_clk ? 7'h0 : rate_cnt + 7'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_div <= 4'h0;
		end else if (sample_tick_clk) begin
			bit_div <= bit_div + 4'h1;
		end
	end
	// ****************************************
	// transmitter
	// ****************************************
	logic [7:0] tx_buf;
	logic tx_buf_full;
	logic [10:0] tx_shift;
	logic [10:0] tx_frame;
	logic [3:0] tx_left;
	logic pre_q;
	logic brk_q;
	wire [3:0] frame_len = char_len_9 ? `ASP_LEN9 : `ASP_LEN8;
	wire tx_slot = bit_tick & (tx_left == 4'h0);
	wire tx_brk = brk_q | send_break_ctl;
	wire tx_any = tx_enable & (pre_q | tx_brk | tx_buf_full);
	wire tx_load = tx_slot & tx_any;
	wire tx_data_go = tx_load & ~pre_q & ~tx_brk;
	wire tx_buf_empty_set = tx_data_go | (tx_slot & ~tx_enable);
	wire tc_set = tx_slot & ~tx_any;
	always_comb begin
		if (pre_q) begin
			tx_frame = 11'h7ff;
		end else if (tx_brk) begin
			tx_frame = 11'h000;
		end else begin
			tx_frame = {1'b1, char_len_9 ? tx_ninth_bit : 1'b1, tx_buf, 1'b0};
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txd <= 1'b1;
			txd_oe <= 1'b0;
			tx_shift <= 11'h7ff;
			tx_left <= 4'h0;
		end else if (bit_tick) begin
			if (tx_left != 4'h0) begin
				txd <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[10:1]};
				tx_left <= tx_left - 4'h1;
			end else if (tx_any) begin
				txd <= tx_frame[0];
				tx_shift <= {1'b1, tx_frame[10:1]};
				tx_left <= frame_len - 4'h1;
			end else begin
				txd <= 1'b1;
			end
			// pin released only on a bit-clock edge with nothing in flight
			txd_oe <= tx_enable | (tx_left != 4'h0);
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_buf <= 8'h00;
		end else if (data_wr) begin
			tx_buf <= hwdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_buf_full <= 1'b0;
			pre_q <= 1'b0;
			brk_q <= 1'b0;
		end else begin
			if (tx_slot & ~tx_enable) begin
				tx_buf_full <= 1'b0;
				pre_q <= 1'b0;
				brk_q <= 1'b0;
			end else if (tx_load) begin
				if (pre_q) begin
					pre_q <= 1'b0;
				end else if (tx_brk) begin
					brk_q <= 1'b0;
				end else begin
					tx_buf_full <= 1'b0;
				end
			end
			if (data_wr) begin
				tx_buf_full <= 1'b1;
			end
			if (te_rise) begin
				pre_q <= 1'b1;
			end
			if (ctlb_wr & hwdata[`ASP_B_SBK]) begin
				brk_q <= 1'b1;
			end
		end
	end
	// ****************************************
	// receiver
	// ****************************************
	asp_pkg::asp_rx_state_t rx_st;
	asp_pkg::asp_rx_char_t rx_hold;
	asp_pkg::asp_rx_char_t rx_new;
	logic [3:0] rx_rt;
	logic [3:0] rx_idx;
	logic [1:0] rx_smp;
	logic [8:0] rx_sh;
	logic rx_noise;
	logic [6:0] flags;
	wire [3:0] dbits = char_len_9 ? `ASP_DBITS9 : `ASP_DBITS8;
	wire vote = (rx_smp[1] & rx_smp[0]) | (rx_smp[1] & rxd) | (rx_smp[0] & rxd);
	wire unan = (rx_smp[1] == rx_smp[0]) & (rx_smp[0] == rxd);
	wire rx_mid = sample_tick_clk & rx_enable & (rx_st == asp_pkg::ASP_RX_RUN) & (rx_rt == `ASP_SMP_C);
	wire rx_done = rx_mid & (rx_idx == dbits + 4'h1);
	wire mark_evt = rx_mid & (rx_idx == dbits) & vote & wake_addr_mark;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st <= asp_pkg::ASP_RX_IDLE;
			rx_rt <= 4'h0;
			rx_idx <= 4'h0;
			rx_smp <= 2'h0;
			rx_sh <= 9'h000;
			rx_noise <= 1'b0;
		end else if (~rx_enable) begin
			rx_st <= asp_pkg::ASP_RX_IDLE;
		end else if (sample_tick_clk) begin
			unique case (rx_st)
				asp_pkg::ASP_RX_IDLE: begin
					if (~rxd) begin
						rx_st <= asp_pkg::ASP_RX_RUN;
						rx_rt <= 4'h0;
						rx_idx <= 4'h0;
						rx_noise <= 1'b0;
					end
				end
				asp_pkg::ASP_RX_RUN: begin
					rx_rt <= rx_rt + 4'h1;
					if ((rx_rt == `ASP_SMP_A) | (rx_rt == `ASP_SMP_B)) begin
						rx_smp <= {rx_smp[0], rxd};
					end
					if (rx_rt == `ASP_SMP_C) begin
						if (~unan) begin
							rx_noise <= 1'b1;
						end
						// a start that votes high was a glitch
						if ((rx_idx == 4'h0) & vote) begin
							rx_st <= asp_pkg::ASP_RX_IDLE;
						end
						if ((rx_idx != 4'h0) & (rx_idx <= dbits)) begin
							rx_sh <= char_len_9 ? {vote, rx_sh[8:1]} : {1'b0, vote, rx_sh[7:1]};
						end
						// ending at mid stop bit gives margin for the next start
						if (rx_idx == dbits + 4'h1) begin
							rx_st <= asp_pkg::ASP_RX_IDLE;
						end
					end
					if (rx_rt == `ASP_RT_LAST) begin
						rx_idx <= rx_idx + 4'h1;
					end
				end
			endcase
		end
	end
	always_comb begin
		rx_new.data = rx_sh[7:0];
		rx_new.ninth = rx_sh[8];
		rx_new.noise = rx_noise | ~unan;
		rx_new.ferr = ~vote;
	end
	wire rx_take = rx_done & ~rx_sleep;
	wire rx_buf_full_set = rx_take & ~flags[`ASP_F_RX_BUF_FULL];
	wire or_set = rx_take & flags[`ASP_F_RX_BUF_FULL];
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_hold <= '0;
		end else if (rx_buf_full_set) begin
			rx_hold <= rx_new;
		end
	end
	// ****************************************
	// idle line detect
	// ****************************************
	logic [7:0] quiet_cnt;
	logic line_busy;
	wire [7:0] quiet_lim = char_len_9 ? `ASP_QUIET9 : `ASP_QUIET8;
	wire idle_evt = sample_tick_clk & rx_enable & rxd & line_busy & (quiet_cnt == quiet_lim);
	assign wake_evt = rx_sleep & ((idle_evt & ~wake_addr_mark) | mark_evt);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			quiet_cnt <= 8'h00;
			line_busy <= 1'b0;
		end else if (sample_tick_clk & rx_enable) begin
			if (~rxd) begin
				quiet_cnt <= 8'h00;
				line_busy <= 1'b1;
			end else if (quiet_cnt != quiet_lim) begin
				quiet_cnt <= quiet_cnt + 8'h01;
			end else begin
				line_busy <= 1'b0;
			end
		end
	end
	// ****************************************
	// status flags
	// ****************************************
	logic [6:0] arm;
	wire [6:0] fset = {tx_buf_empty_set, tc_set, rx_buf_full_set, idle_evt & ~rx_sleep, or_set,
		rx_buf_full_set & rx_new.noise, rx_buf_full_set & rx_new.ferr};
	localparam logic [6:0] WR_MASK = `ASP_WR_CLR_MASK;
	localparam logic [6:0] F_RST = `ASP_FLAG_RST;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_flag
			wire clr_evt = WR_MASK[gi] ? data_wr : data_rd;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					flags[gi] <= F_RST[gi];
				end else if (fset[gi]) begin
					flags[gi] <= 1'b1;
				end else if (clr_evt & arm[gi]) begin
					flags[gi] <= 1'b0;
				end
			end
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					arm[gi] <= 1'b0;
				end else if (stat_rd & flags[gi]) begin
					arm[gi] <= 1'b1;
				end else if (clr_evt) begin
					arm[gi] <= 1'b0;
				end
			end
		end
	endgenerate
	// ****************************************
	// read mux and interrupt
	// ****************************************
	always_comb begin
		case (ap.addr)
			`ASP_OFF_DATA: rd_val = rx_hold.data;
			`ASP_OFF_CTLA: rd_val = {rx_hold.ninth, tx_ninth_bit, 1'b0, char_len_9, wake_addr_mark, 3'h0};
			`ASP_OFF_CTLB: rd_val = {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, line_quiet_irq_en,
				tx_enable, rx_enable, rx_sleep, send_break_ctl};
			`ASP_OFF_STAT: rd_val = {flags, 1'b0};
			`ASP_OFF_BAUD: rd_val = {2'h0, prescale_sel, 1'b0, rate_div_sel};
			default: rd_val = 8'h00;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h0;
		end else if (rd_pend) begin
			hrdata <= {24'h0, rd_val};
		end
	end
	// noise and framing flags stay out of the request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (flags[`ASP_F_TX_BUF_EMPTY] & tx_empty_irq_en) | (flags[`ASP_F_TC] & tx_done_irq_en)
				| (~rx_sleep & rx_full_irq_en & (flags[`ASP_F_RX_BUF_FULL] | flags[`ASP_F_OR]))
				| (~rx_sleep & line_quiet_irq_en & flags[`ASP_F_IDLE]);
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	data_read_a: assert property (data_rd |=> hrdata[7:0] == $past(rx_hold.data))
		else $error("data read not from receive buffer");
	frame_len_a: assert property (tx_load |=> tx_left == $past(frame_len) - 4'h1)
		else $error("wrong transmit frame length");
	irq_tx_a: assert property (flags[`ASP_F_TX_BUF_EMPTY] && tx_empty_irq_en |=> irq)
		else $error("tx empty irq missing");
	irq_rx_a: assert property (rx_full_irq_en && !rx_sleep && (flags[`ASP_F_RX_BUF_FULL] || flags[`ASP_F_OR]) |=> irq)
		else $error("receive irq missing");
	irq_idle_a: assert property (line_quiet_irq_en && !rx_sleep && flags[`ASP_F_IDLE] |=> irq)
		else $error("idle irq missing");
	pre_queue_a: assert property (te_rise |=> pre_q)
		else $error("preamble not queued");
	brk_queue_a: assert property (ctlb_wr && hwdata[`ASP_B_SBK] |=> brk_q ##1 (brk_q || $past(tx_slot)))
		else $error("break not queued");
	sleep_quiet_a: assert property (rx_sleep |=> !$rose(flags[`ASP_F_RX_BUF_FULL]))
		else $error("receive flag set while asleep");
	tx_buf_empty_clear_a: assert property ($fell(flags[`ASP_F_TX_BUF_EMPTY]) |-> $past(data_wr && arm[`ASP_F_TX_BUF_EMPTY]))
		else $error("tx empty cleared without sequence");
	overrun_keep_a: assert property (or_set |=> flags[`ASP_F_OR] && rx_hold == $past(rx_hold))
		else $error("overrun disturbed buffer");
	rx_char_c: cover property (rx_buf_full_set);
	overrun_c: cover property (or_set);
	idle_c: cover property (idle_evt ##[1:1000] rx_buf_full_set);
	tx_data_c: cover property (tx_data_go);
endmodule
`default_nettype wire

//--- asp_defs.svh
// Purpose: named offsets, field positions, reset values and counts of the serial port
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: definitions only
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define ASP_OFF_DATA 8'h00
`define ASP_OFF_CTLA 8'h04
`define ASP_OFF_CTLB 8'h08
`define ASP_OFF_STAT 8'h0c
`define ASP_OFF_BAUD 8'h10
// ****************************************
// field positions
// ****************************************
`define ASP_A_R8 7
`define ASP_A_T8 6
`define ASP_A_M 4
`define ASP_A_WAKE 3
`define ASP_B_TIE 7
`define ASP_B_TX_DONE_IRQ_EN 6
`define ASP_B_RIE 5
`define ASP_B_LINE_QUIET_IRQ_EN 4
`define ASP_B_TE 3
`define ASP_B_RE 2
`define ASP_B_RWU 1
`define ASP_B_SBK 0
`define ASP_F_TX_BUF_EMPTY 6
`define ASP_F_TC 5
`define ASP_F_RX_BUF_FULL 4
`define ASP_F_IDLE 3
`define ASP_F_OR 2
`define ASP_F_NF 1
`define ASP_F_FE 0
`define ASP_BD_PRE_HI 5
`define ASP_BD_PRE_LO 4
`define ASP_BD_RATE_HI 2
`define ASP_BD_RATE_LO 0
// ****************************************
// reset values and counts
// ****************************************
`define ASP_FLAG_RST 7'h60
`define ASP_WR_CLR_MASK 7'h60
`define ASP_PRE_T0 4'h0
`define ASP_PRE_T1 4'h2
`define ASP_PRE_T2 4'h3
`define ASP_PRE_T3 4'hc
`define ASP_RT_LAST 4'hf
`define ASP_SMP_A 4'h7
`define ASP_SMP_B 4'h8
`define ASP_SMP_C 4'h9
`define ASP_LEN8 4'ha
`define ASP_LEN9 4'hb
`define ASP_DBITS8 4'h8
`define ASP_DBITS9 4'h9
`define ASP_QUIET8 8'ha0
`define ASP_QUIET9 8'hb0
`endif

//--- asp_pkg.sv
// Purpose: types shared by the serial port
// Assumes: nothing
// Notes: no constants here, see asp_defs.svh
`default_nettype none
package asp_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
	} asp_aphase_t;
	typedef struct packed {
		logic [7:0] data;
		logic ninth;
		logic noise;
		logic ferr;
	} asp_rx_char_t;
	typedef enum logic [0:0] {
		ASP_RX_IDLE = 1'b0,
		ASP_RX_RUN = 1'b1
	} asp_rx_state_t;
endpackage
`default_nettype wire

//--- asp_peer_node.sv
// Purpose: remote serial node facing the port's serial lines
// Assumes: shares clk with the bench; bclks clocks per bit, nbits data bits
// Notes: line idles high, so a released line shows 1
`timescale 1ns/1ps
`default_nettype none
module asp_peer_node (
	// clock
	input wire logic clk,
	// serial lines
	input wire logic txd,
	output logic rxd
);
	int bclks = 16;
	int nbits = 8;
	int n_got = 0;
	logic [8:0] got = 9'h000;
	logic got_stop = 1'b1;
	initial rxd = 1'b1;
	// low start, lsb first, chosen stop level, then two idle bits
	task automatic send(input logic [8:0] d, input logic stp);
		rxd <= 1'b0;
		repeat (bclks) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			rxd <= d[i];
			repeat (bclks) @(posedge clk);
		end
		rxd <= stp;
		repeat (bclks) @(posedge clk);
		rxd <= 1'b1;
		repeat (2 * bclks) @(posedge clk);
	endtask
	// decode device frames at mid bit; a preamble has no start edge
	always begin
		@(negedge txd);
		got = 9'h000;
		repeat (bclks / 2) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			repeat (bclks) @(posedge clk);
			got[i] = txd;
		end
		repeat (bclks) @(posedge clk);
		got_stop = txd;
		n_got++;
	end
endmodule
`default_nettype wire

//--- async_serial_port_regs_tb_top.sv
// Purpose: register level test of the serial port against a remote node
// Assumes: one slave, so hready is the slave's hreadyout
// Notes: bit rate divisors exercised on the transmit side
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_regs_tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout, hresp, txd, txd_oe, irq, rxd;
	logic [31:0] hrdata;
	logic [7:0] rv;
	logic low;
	int bad_count = 0;
	int n_checks = 0;
	logic [7:0] bd [6] = '{8'h10, 8'h20, 8'h30, 8'h01, 8'h07, 8'h00};
	int bc [6] = '{48, 64, 208, 32, 2048, 16};
	always #4 clk = ~clk;
	asp_serial_port u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq));
	asp_peer_node u_peer (.clk(clk), .txd(txd), .rxd(rxd));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single ahb-lite transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h000000, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rv = hrdata[7:0];
		chk("hresp", {8'h00, hresp}, 9'h000);
	endtask
	task automatic wait_got(input int n);
		for (int k = 0; k < 30000 && u_peer.n_got < n; k++) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		xfer(1'b0, 8'h0c, 8'h00);
		chk("status", rv, 8'hc0);
		chk("oe off", {8'h00, txd_oe}, 9'h000);
		xfer(1'b0, 8'h14, 8'h00);
		chk("unmapped", rv, 8'h00);
		xfer(1'b1, 8'h10, 8'h00);
		xfer(1'b1, 8'h08, 8'h08);
		xfer(1'b0, 8'h0c, 8'h00);
		xfer(1'b1, 8'h00, 8'h3c);
		low = 1'b0;
		repeat (140) begin
			@(posedge clk);
			low = low | ~txd;
		end
		chk("preamble", {8'h00, low}, 9'h000);
		wait_got(1);
		chk("tx char", u_peer.got, 9'h03c);
		chk("oe on", {8'h00, txd_oe}, 9'h001);
		// prescaler and rate codes: the peer decodes at the expected bit length
		for (int i = 0; i < 6; i++) begin
			u_peer.bclks = bc[i];
			xfer(1'b1, 8'h10, bd[i]);
			xfer(1'b0, 8'h0c, 8'h00);
			xfer(1'b1, 8'h00, 8'h50 + 8'(i));
			wait_got(i + 2);
			chk("tx rate", u_peer.got, 9'h050 + 9'(i));
			chk("tx stop", {8'h00, u_peer.got_stop}, 9'h001);
			repeat (2 * bc[i]) @(posedge clk);
		end
		xfer(1'b1, 8'h08, 8'h88);
		repeat (3) @(posedge clk);
		chk("tx_buf_empty irq", {8'h00, irq}, 9'h001);
		xfer(1'b1, 8'h08, 8'h48);
		repeat (40) @(posedge clk);
		chk("tc irq", {8'h00, irq}, 9'h001);
		xfer(1'b1, 8'h08, 8'h08);
		repeat (3) @(posedge clk);
		chk("irq off", {8'h00, irq}, 9'h000);
		xfer(1'b1, 8'h08, 8'h09);
		xfer(1'b1, 8'h08, 8'h08);
		wait_got(8);
		chk("break", {u_peer.got_stop, u_peer.got[7:0]}, 9'h000);
		// receive path
		xfer(1'b1, 8'h08, 8'h2c);
		u_peer.send(9'h0a5, 1'b1);
		repeat (4) @(posedge clk);
		chk("rx irq", {8'h00, irq}, 9'h001);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("rx flags", rv & 8'h2e, 8'h20);
		xfer(1'b0, 8'h00, 8'h00);
		chk("rx data", rv, 8'ha5);
		repeat (3) @(posedge clk);
		chk("rx irq clr", {8'h00, irq}, 9'h000);
		xfer(1'b1, 8'h08, 8'h1c);
		repeat (200) @(posedge clk);
		chk("idle irq", {8'h00, irq}, 9'h001);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("idle", rv & 8'h10, 8'h10);
		xfer(1'b0, 8'h00, 8'h00);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("idle once", rv & 8'h10, 8'h00);
		xfer(1'b1, 8'h08, 8'h0c);
		u_peer.send(9'h011, 1'b1);
		u_peer.send(9'h022, 1'b1);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("overrun", rv & 8'h28, 8'h28);
		xfer(1'b0, 8'h00, 8'h00);
		chk("kept", rv, 8'h11);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("or clr", rv & 8'h28, 8'h00);
		u_peer.send(9'h055, 1'b0);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("frame err", rv & 8'h22, 8'h22);
		chk("no fe irq", {8'h00, irq}, 9'h000);
		xfer(1'b0, 8'h00, 8'h00);
		// nine bit frames both ways
		xfer(1'b1, 8'h04, 8'h50);
		u_peer.nbits = 9;
		u_peer.send(9'h1c3, 1'b1);
		xfer(1'b0, 8'h0c, 8'h00);
		xfer(1'b0, 8'h04, 8'h00);
		chk("rx ninth", rv & 8'h80, 8'h80);
		xfer(1'b0, 8'h00, 8'h00);
		chk("rx9 data", rv, 8'hc3);
		xfer(1'b1, 8'h00, 8'h3c);
		wait_got(9);
		chk("tx ninth", u_peer.got, 9'h13c);
		// address mark wakeup
		u_peer.nbits = 8;
		xfer(1'b1, 8'h04, 8'h08);
		xfer(1'b1, 8'h08, 8'h0e);
		u_peer.send(9'h001, 1'b1);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("asleep", rv & 8'h20, 8'h00);
		u_peer.send(9'h081, 1'b1);
		xfer(1'b0, 8'h0c, 8'h00);
		chk("woken", rv & 8'h20, 8'h20);
		xfer(1'b0, 8'h08, 8'h00);
		chk("sleep clr", rv & 8'h02, 8'h00);
		xfer(1'b0, 8'h00, 8'h00);
		chk("mark data", rv, 8'h81);
		complete_run();
	end
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule
`default_nettype wire
